/* rtl/aso_top.sv */
/*
 * Sequencer top: AXI4-Lite registers, pin synchronisers, fault list,
 * relay and interrupt. Pins are asynchronous; other inputs on clk_sys.
 */
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
// Contract
// - Torque off cuts the power stage at once.
// - Software disable follows the configured disable mode.
// - Disable mode 0 switches the axis off immediately.
// - Disable mode 2 decelerates first, then disables the axis.
// - Any stop brakes at zero speed or timeout.
// - Stop input decelerates, disables, then brakes.
// - Immediate brake setting brakes at once on torque off.
// - Immediate brake setting brakes at once on a fault cut.
// - Faults react by power cut, dynamic braking or controlled stop.
// - Fault relay output is driven while any fault is active.
// - Faults and warnings carry a group code and an identifier.
// - Group codes follow the fixed two-digit encoding table.
// - Faults readable per axis; warnings per axis and drive wide.
// - Several faults may be active and all are reported; the list holds eight, extra events only set an interrupt bit.
// - Drive-wide list entries give axis number then group-id code.
// - Warnings never stop the axis; faults stop it by severity.
module aso_top
    import aso_pkg::*;
#(
    parameter int CYC_PER_MS = CYC_PER_UNIT
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NAX-1:0] safe_torque_off_input,
    input wire logic [NAX-1:0] hardware_enable_input,
    input wire logic [NAX-1:0] stop_input,
    input wire logic [NAX-1:0][15:0] speed_mag,
    input wire aso_event_t event_in,
    output aso_axis_out_t [NAX-1:0] axis_out,
    output logic fault_relay_output,
    output logic irq
);
    localparam int NPIN = 3 * NAX;

    function automatic logic [31:0] wmerge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
            if (s[b])
                r[8*b +: 8] = n[8*b +: 8];
        return r;
    endfunction

    function automatic logic [3:0] popcnt(logic [LIST_DEPTH-1:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < LIST_DEPTH; i++)
            c = c + {3'h0, v[i]};
        return c;
    endfunction

    // AXI4-Lite write path: address and data may come in either order
    logic aw_ok_r;
    logic w_ok_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_go;
    logic wr_map;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] rd_val;
    logic rd_map;

    assign s_axi_awready = !aw_ok_r && !bvalid_r;
    assign s_axi_wready = !w_ok_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign wr_go = aw_ok_r && w_ok_r && !bvalid_r;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ok_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ok_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // Pin synchronisers: a change counts once stages two and three agree
    logic [NPIN-1:0] s1_r;
    logic [NPIN-1:0] s2_r;
    logic [NPIN-1:0] s3_r;
    logic [NPIN-1:0] pin_r;
    logic [NAX-1:0] sto_ok;
    logic [NAX-1:0] hw_en;
    logic [NAX-1:0] di_stop;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end
        else
        begin
            s1_r <= {stop_input, hardware_enable_input, safe_torque_off_input};
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < NPIN; i++)
                if (s2_r[i] == s3_r[i])
                    pin_r[i] <= s3_r[i];
        end
    end

    assign sto_ok = pin_r[NAX-1:0];
    assign hw_en = pin_r[2*NAX-1:NAX];
    assign di_stop = pin_r[3*NAX-1:2*NAX];

    // Millisecond tick for the stop timeout
    logic [31:0] pre_r;
    logic ms_tick;

    assign ms_tick = pre_r == 32'(CYC_PER_MS - 1);

    always_ff @(posedge clk_sys)
    begin
        if (reset || ms_tick)
            pre_r <= 32'h0000_0000;
        else
            pre_r <= pre_r + 32'h0000_0001;
    end

    // Control and configuration registers
    logic [NAX-1:0] sw_en_r;
    logic [NAX-1:0] sw_dis_r;
    logic [31:0] cfg_r;
    logic [NAX-1:0][15:0] zerov_r;
    logic [NAX-1:0][15:0] zerot_r;
    logic [NAX-1:0] stop_done;
    logic [31:0] wr_val;

    assign wr_val = wmerge(32'h0000_0000, wdata_r, wstrb_r);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sw_en_r <= '0;
            sw_dis_r <= '0;
        end
        else
        begin
            sw_dis_r <= '0;
            for (int a = 0; a < NAX; a++)
            begin
                // A finished stop drops the software enable so a restart is explicit
                if (stop_done[a])
                    sw_en_r[a] <= 1'b0;
                if (wr_go && awaddr_r == A_CTRL)
                begin
                    if (wr_val[CTRL_DIS_LSB + a])
                    begin
                        sw_en_r[a] <= 1'b0;
                        sw_dis_r[a] <= sw_en_r[a];
                    end
                    else if (wr_val[CTRL_EN_LSB + a])
                        sw_en_r[a] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            cfg_r <= RST_CFG;
            for (int a = 0; a < NAX; a++)
            begin
                zerov_r[a] <= RST_ZEROV;
                zerot_r[a] <= RST_ZEROT;
            end
        end
        else if (wr_go)
        begin
            if (awaddr_r == A_CFG)
                cfg_r <= wmerge(cfg_r, wdata_r, wstrb_r);
            for (int a = 0; a < NAX; a++)
            begin
                if (awaddr_r == A_ZV0 + 8'(a * A_AX_STRIDE))
                    zerov_r[a] <= 16'(wmerge({16'h0000, zerov_r[a]}, wdata_r, wstrb_r));
                if (awaddr_r == A_ZT0 + 8'(a * A_AX_STRIDE))
                    zerot_r[a] <= 16'(wmerge({16'h0000, zerot_r[a]}, wdata_r, wstrb_r));
            end
        end
    end

    // Fault and warning list shared by all axes
    aso_entry_t list_r [LIST_DEPTH];
    aso_entry_t new_ent;
    logic [LIST_DEPTH-1:0] vmask;
    logic [NAX-1:0][LIST_DEPTH-1:0] fmask;
    logic [NAX-1:0][LIST_DEPTH-1:0] wmask;
    logic [NAX-1:0] flt_act;
    logic dup;
    logic free_ok;
    logic [2:0] free_idx;
    logic [NAX-1:0] fclr_f;
    logic [NAX-1:0] fclr_w;

    assign new_ent = '{valid: 1'b1, warn: event_in.warn, axis: event_in.axis,
        code: {aso_group_code(event_in.grp, event_in.fb_num), event_in.id}};

    always_comb
    begin
        dup = 1'b0;
        free_ok = 1'b0;
        free_idx = 3'h0;
        for (int i = LIST_DEPTH - 1; i >= 0; i--)
        begin
            vmask[i] = list_r[i].valid;
            if (list_r[i] == new_ent)
                dup = 1'b1;
            if (!list_r[i].valid)
            begin
                free_ok = 1'b1;
                free_idx = 3'(i);
            end
            for (int a = 0; a < NAX; a++)
            begin
                fmask[a][i] = list_r[i].valid && !list_r[i].warn && list_r[i].axis == 1'(a);
                wmask[a][i] = list_r[i].valid && list_r[i].warn && list_r[i].axis == 1'(a);
            end
        end
        for (int a = 0; a < NAX; a++)
        begin
            flt_act[a] = |fmask[a];
            fclr_f[a] = wr_go && awaddr_r == A_FCLR && wr_val[a];
            fclr_w[a] = wr_go && awaddr_r == A_FCLR && wr_val[FCLR_WARN_LSB + a];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            for (int i = 0; i < LIST_DEPTH; i++)
                list_r[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < LIST_DEPTH; i++)
                if (list_r[i].warn ? fclr_w[list_r[i].axis] : fclr_f[list_r[i].axis])
                    list_r[i].valid <= 1'b0;
            // A new entry written after the clear, so it survives it
            if (event_in.valid && !dup && free_ok)
                list_r[free_idx] <= new_ent;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            fault_relay_output <= 1'b0;
        else
            fault_relay_output <= |flt_act;
    end

    // Interrupt status, write one to clear; a new event wins over the clear
    logic [IRQ_W-1:0] istat_r;
    logic [IRQ_W-1:0] imask_r;
    logic [IRQ_W-1:0] iset;
    logic [2:0] lsel_r;

    assign iset = {stop_done,
        event_in.valid && !dup && !free_ok,
        event_in.valid && !dup && free_ok && event_in.warn,
        event_in.valid && !dup && free_ok && !event_in.warn};

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            istat_r <= '0;
            imask_r <= '0;
            lsel_r <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_go && awaddr_r == A_ISTAT)
                istat_r <= (istat_r & ~wr_val[IRQ_W-1:0]) | iset;
            else
                istat_r <= istat_r | iset;
            if (wr_go && awaddr_r == A_IMASK)
                imask_r <= wr_val[IRQ_W-1:0];
            if (wr_go && awaddr_r == A_LSEL)
                lsel_r <= wr_val[2:0];
            irq <= |(istat_r & imask_r);
        end
    end

    // One sequencer per axis; warnings never reach it
    for (genvar a = 0; a < NAX; a++)
    begin : g_ax
        aso_axis_seq u_seq (
            .clk_sys(clk_sys),
            .reset(reset),
            .run_ok(hw_en[a] && sw_en_r[a] && sto_ok[a] && !flt_act[a]),
            .sto_ok(sto_ok[a]),
            .hw_en(hw_en[a]),
            .sw_dis(sw_dis_r[a]),
            .di_stop(di_stop[a]),
            .flt(event_in.valid && !event_in.warn && event_in.axis == 1'(a)),
            .flt_react(event_in.react),
            .mode(cfg_r[CFG_MODE_LSB + 2*a +: 2]),
            .imm_brake(cfg_r[CFG_IMM_LSB + a]),
            .dyn_to_imm(cfg_r[CFG_DYN2IMM_BIT]),
            .zerov(zerov_r[a]),
            .zerot(zerot_r[a]),
            .ms_tick(ms_tick),
            .speed(speed_mag[a]),
            .ax_out(axis_out[a]),
            .stop_done(stop_done[a])
        );
    end

    // Read path
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_map = 1'b1;
        unique case (s_axi_araddr)
            A_CTRL: rd_val = 32'(sw_en_r);
            A_CFG: rd_val = cfg_r;
            A_ZV0: rd_val = {16'h0000, zerov_r[0]};
            A_ZT0: rd_val = {16'h0000, zerot_r[0]};
            A_ZV0 + A_AX_STRIDE: rd_val = {16'h0000, zerov_r[1]};
            A_ZT0 + A_AX_STRIDE: rd_val = {16'h0000, zerot_r[1]};
            A_STAT:
                for (int a = 0; a < NAX; a++)
                    rd_val[STAT_AX_W*a +: STAT_AX_W] = {sw_en_r[a], flt_act[a], axis_out[a]};
            A_ISTAT: rd_val = 32'(istat_r);
            A_IMASK: rd_val = 32'(imask_r);
            A_LSEL: rd_val = 32'(lsel_r);
            // Entry: valid, warning flag, axis number from one, group and id digits
            A_LDATA: rd_val = {list_r[lsel_r].valid, 6'h00, list_r[lsel_r].warn,
                4'h0, 4'(list_r[lsel_r].axis) + 4'h1, list_r[lsel_r].code};
            A_CNT:
                for (int a = 0; a < NAX; a++)
                    rd_val[CNT_AX_W*a +: CNT_AX_W] = {popcnt(wmask[a]), popcnt(fmask[a])};
            A_FCLR: rd_val = 32'(popcnt(vmask));
            default: rd_map = 1'b0;
        endcase
    end

    assign wr_map = awaddr_r[1:0] == 2'h0 && awaddr_r <= A_CNT;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
    end
endmodule

/* rtl/aso_pkg.sv */
/*
 * Constants, types and helpers of the switch-off sequencer.
 * Assumes a 40 MHz system clock and a two-axis drive.
 */
package aso_pkg;
    localparam int NAX = 2;
    localparam int CLK_HZ = 40_000_000;
    // Stop timeout limit is kept in milliseconds
    localparam int ZEROT_UNIT_US = 1000;
    localparam int CYC_PER_UNIT = (CLK_HZ / 1_000_000) * ZEROT_UNIT_US;
    localparam int LIST_DEPTH = 8;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CFG = 8'h04;
    localparam logic [7:0] A_ZV0 = 8'h08;
    localparam logic [7:0] A_ZT0 = 8'h0c;
    localparam logic [7:0] A_AX_STRIDE = 8'h08;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_ISTAT = 8'h1c;
    localparam logic [7:0] A_IMASK = 8'h20;
    localparam logic [7:0] A_LSEL = 8'h24;
    localparam logic [7:0] A_LDATA = 8'h28;
    localparam logic [7:0] A_FCLR = 8'h2c;
    localparam logic [7:0] A_CNT = 8'h30;

    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_DIS_LSB = 8;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_IMM_LSB = 4;
    localparam int CFG_DYN2IMM_BIT = 6;
    localparam int FCLR_WARN_LSB = 8;
    localparam int STAT_AX_W = 8;
    localparam int CNT_AX_W = 8;

    localparam logic [15:0] RST_ZEROV = 16'h0010;
    localparam logic [15:0] RST_ZEROT = 16'h01f4;
    localparam logic [31:0] RST_CFG = 32'h0000_0000;

    localparam int IRQ_W = 5;

    localparam logic [1:0] DM_IMMED = 2'h0;
    localparam logic [1:0] DM_CTRL = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RUN = 2'b01,
        ST_DECEL = 2'b11,
        ST_COAST = 2'b10
    } aso_state_t;

    typedef enum logic [1:0] {
        RX_IMMED = 2'h0,
        RX_DYN = 2'h1,
        RX_CTRL = 2'h2
    } aso_react_t;

    typedef enum logic [3:0] {
        G_SYS, G_FILE, G_HW, G_PWR, G_TEMP, G_SW,
        G_FB, G_MOTOR, G_WAKE, G_MOTION, G_FBUS, G_SAFETY
    } aso_grp_t;

    typedef struct packed {
        logic valid;
        logic warn;
        logic [0:0] axis;
        aso_grp_t grp;
        logic [3:0] fb_num;
        logic [7:0] id;
        aso_react_t react;
    } aso_event_t;

    typedef struct packed {
        logic valid;
        logic warn;
        logic [0:0] axis;
        logic [15:0] code;
    } aso_entry_t;

    typedef struct packed {
        logic power_on;
        logic brake;
        logic decel_req;
        logic dyn_brake;
        aso_state_t state;
    } aso_axis_out_t;

    // Group code as two BCD digits
    function automatic logic [7:0] aso_group_code(aso_grp_t g, logic [3:0] n);
        unique case (g)
            G_SYS: return 8'h10;
            G_FILE: return 8'h11;
            G_HW: return 8'h15;
            G_PWR: return 8'h20;
            G_TEMP: return 8'h25;
            G_SW: return 8'h30;
            G_FB: return {4'h4, n};
            G_MOTOR: return 8'h50;
            G_WAKE: return 8'h55;
            G_MOTION: return 8'h60;
            G_FBUS: return 8'h70;
            G_SAFETY: return 8'h90;
            default: return 8'h00;
        endcase
    endfunction
endpackage

/* rtl/aso_axis_seq.sv */
/*
 * One axis of the switch-off sequencer: enable, stop sequences, brake.
 * Assumes synchronised, debounced inputs and a millisecond tick.
 */
`timescale 1ns/10ps
module aso_axis_seq
    import aso_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic run_ok,
    input wire logic sto_ok,
    input wire logic hw_en,
    input wire logic sw_dis,
    input wire logic di_stop,
    input wire logic flt,
    input wire aso_react_t flt_react,
    input wire logic [1:0] mode,
    input wire logic imm_brake,
    input wire logic dyn_to_imm,
    input wire logic [15:0] zerov,
    input wire logic [15:0] zerot,
    input wire logic ms_tick,
    input wire logic [15:0] speed,
    output aso_axis_out_t ax_out,
    output logic stop_done
);
    aso_state_t state_r;
    aso_state_t state_nxt;
    logic imm_r;
    logic imm_nxt;
    logic dyn_r;
    logic dyn_nxt;
    logic [15:0] tcnt_r;
    logic at_zero;
    logic tmo;
    logic power_cut;
    aso_react_t rx;

    assign at_zero = speed <= zerov;
    assign tmo = tcnt_r >= zerot;
    // Dynamic braking may be configured as a plain power cut
    assign rx = (flt_react == RX_DYN && dyn_to_imm) ? RX_IMMED : flt_react;
    assign power_cut = !sto_ok || !hw_en || (flt && rx != RX_CTRL);

    always_comb
    begin
        state_nxt = state_r;
        imm_nxt = imm_r;
        dyn_nxt = dyn_r;
        unique case (state_r)
            ST_OFF:
            begin
                imm_nxt = 1'b0;
                dyn_nxt = 1'b0;
                if (run_ok)
                    state_nxt = ST_RUN;
            end
            ST_RUN, ST_DECEL:
            begin
                if (power_cut)
                begin
                    state_nxt = ST_COAST;
                    imm_nxt = imm_brake;
                    dyn_nxt = flt && rx == RX_DYN;
                end
                else if (state_r == ST_DECEL)
                begin
                    if (at_zero || tmo)
                        state_nxt = ST_OFF;
                end
                else if (sw_dis)
                    state_nxt = (mode == DM_CTRL) ? ST_DECEL : ST_COAST;
                else if (di_stop || flt)
                    state_nxt = ST_DECEL;
            end
            ST_COAST:
            begin
                if (at_zero || tmo)
                    state_nxt = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_r <= ST_OFF;
            imm_r <= 1'b0;
            dyn_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            imm_r <= imm_nxt;
            dyn_r <= dyn_nxt;
        end
    end

    // Timer clears while the axis runs or is off, so it restarts at each stop
    always_ff @(posedge clk_sys)
    begin
        if (reset || state_r == ST_RUN || state_r == ST_OFF)
            tcnt_r <= 16'h0000;
        else if (ms_tick && !tmo)
            tcnt_r <= tcnt_r + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ax_out <= '{power_on: 1'b0, brake: 1'b1, decel_req: 1'b0,
                        dyn_brake: 1'b0, state: ST_OFF};
            stop_done <= 1'b0;
        end
        else
        begin
            ax_out.power_on <= state_nxt == ST_RUN || state_nxt == ST_DECEL;
            ax_out.brake <= state_nxt == ST_OFF || (state_nxt == ST_COAST && imm_nxt);
            ax_out.decel_req <= state_nxt == ST_DECEL;
            ax_out.dyn_brake <= state_nxt == ST_COAST && dyn_nxt;
            ax_out.state <= state_nxt;
            stop_done <= state_nxt == ST_OFF && state_r != ST_OFF;
        end
    end
endmodule

/* sim/aso_chk_asserts.sv */
/* Axis 0 checks bound to aso_top; assume reset thresholds. */
`timescale 1ns/10ps
module aso_chk
    import aso_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [NAX-1:0] safe_torque_off_input,
    input wire logic [NAX-1:0] hardware_enable_input,
    input wire logic [NAX-1:0][15:0] speed_mag,
    input wire aso_event_t event_in,
    input wire aso_axis_out_t [NAX-1:0] axis_out,
    input wire logic fault_relay_output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    aso_axis_out_t a;
    assign a = axis_out[0];
    // Eight cycles cover the pin synchroniser plus the output register
    AST_STO_CUT: assert property (!safe_torque_off_input[0] [*8] |-> !a.power_on)
        else $error("power on in torque off");
    AST_EN_PINS: assert property ($rose(a.power_on) |-> $past(hardware_enable_input[0], 3)
        && $past(safe_torque_off_input[0], 3)) else $error("no enable pins");
    AST_DECEL: assert property (a.state == ST_DECEL |-> a.power_on && a.decel_req && !a.brake)
        else $error("bad decel outputs");
    AST_COAST: assert property (a.state == ST_COAST |-> !a.power_on && !a.decel_req)
        else $error("power on in coast");
    AST_OFF: assert property (a.state == ST_OFF |-> a.brake && !a.power_on)
        else $error("brake free when off");
    AST_ZEROV: assert property (a.state inside {ST_DECEL, ST_COAST} &&
        speed_mag[0] <= RST_ZEROV |-> ##[1:3] a.state == ST_OFF) else $error("no stop at zero");
    AST_RELAY: assert property (event_in.valid && !event_in.warn |-> ##[1:4] fault_relay_output)
        else $error("relay not set");
    AST_WARN: assert property (event_in.valid && event_in.warn && a.state == ST_RUN
        |=> a.state == ST_RUN [*3]) else $error("warning stopped axis");
endmodule
bind aso_top aso_chk aso_chk_inst (.*);

/* sim/aso_motor.sv */
/* Motor model of both axes; assumes stall freezes speed. */
`timescale 1ns/10ps
module aso_motor
    import aso_pkg::*;
(
    input wire logic clk_sys,
    input wire logic stall,
    input wire aso_axis_out_t [NAX-1:0] axis_out,
    output logic [NAX-1:0][15:0] speed_mag
);
    initial speed_mag = '0;
    always @(posedge clk_sys)
        for (int i = 0; i < NAX; i++)
            if (axis_out[i].power_on && !axis_out[i].decel_req)
                speed_mag[i] <= 16'h0300;
            else if (!stall)
                speed_mag[i] <= (speed_mag[i] > 16'h0020) ? speed_mag[i] - 16'h0020 : '0;
endmodule

/* sim/tb_top.sv */
/* Bench with motor model; assumes a 4-cycle millisecond. */
`timescale 1ns/10ps
module tb_top
    import aso_pkg::*;
;
    logic clk_sys = 0, reset = 1, stall = 0, fault_relay_output, irq;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [NAX-1:0] safe_torque_off_input = '1, hardware_enable_input = '1, stop_input = '0;
    logic [NAX-1:0][15:0] speed_mag;
    aso_event_t event_in = '0;
    aso_axis_out_t [NAX-1:0] axis_out;
    int miscompares = 0, samples_checked = 0;
    localparam logic [7:0] GC [12] = '{8'h10, 8'h11, 8'h15, 8'h20, 8'h25, 8'h30,
        8'h43, 8'h50, 8'h55, 8'h60, 8'h70, 8'h90};
    localparam logic [31:0] LX [3] = '{32'h8101_5021, 32'h8001_2021, 32'h8002_9021};

    aso_top #(.CYC_PER_MS(4)) aso_top_inst (.*);
    aso_motor aso_motor_inst (.*);
    initial forever #12.5 clk_sys = ~clk_sys;

    task conclude;
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task hang;
        miscompares++;
        $display("ERROR %0t: wait timed out", $time);
        conclude();
    endtask
    // Bready stays high: the response is taken where bvalid is seen
    task wr(logic [7:0] a, logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        if (n == 40)
            hang();
        chk(s_axi_bresp, RESP_OKAY);
    endtask
    task rdr(logic [7:0] a, logic [31:0] exp, logic [1:0] rsp);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk_sys);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        if (n == 40)
            hang();
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, rsp);
    endtask
    task wst(int ax, aso_state_t st);
        int n;
        for (n = 0; n < 3000 && axis_out[ax].state !== st; n++)
            @(posedge clk_sys);
        if (n == 3000)
            hang();
    endtask
    task en(int ax);
        wr(A_CTRL, 32'h1 << ax);
        wst(ax, ST_RUN);
    endtask
    task ev(logic w, ax, aso_grp_t g, aso_react_t r);
        event_in <= '{1'b1, w, ax, g, 4'h3, 8'h21, r};
        @(posedge clk_sys);
        event_in.valid <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task s_dis(logic [1:0] m);
        wr(A_CFG, {30'h0, m});
        en(0);
        wr(A_CTRL, 32'h0000_0100);
        wst(0, (m == DM_CTRL) ? ST_DECEL : ST_COAST);
        chk(axis_out[0].brake, 0);
        wst(0, ST_OFF);
    endtask
    task s_sto;
        wr(A_CFG, 32'h0000_0010);
        en(0);
        stall <= 1'b1;
        safe_torque_off_input[0] <= 1'b0;
        wst(0, ST_COAST);
        chk(axis_out[0].brake, 1);
        wst(0, ST_OFF);
        stall <= 1'b0;
        safe_torque_off_input[0] <= 1'b1;
    endtask
    task s_stop;
        wr(A_CFG, '0);
        en(0);
        stop_input[0] <= 1'b1;
        wst(0, ST_DECEL);
        wst(0, ST_OFF);
        stop_input[0] <= 1'b0;
    endtask
    task s_flt;
        wr(A_CFG, 32'h0000_0010);
        wr(A_IMASK, 32'h0000_0003);
        en(0);
        en(1);
        ev(1'b1, 1'b0, G_MOTOR, RX_IMMED);
        chk(axis_out[0].state, ST_RUN);
        ev(1'b0, 1'b0, G_PWR, RX_DYN);
        chk(32'(axis_out[0]), {26'h0, 4'b0101, ST_COAST});
        ev(1'b0, 1'b1, G_SAFETY, RX_CTRL);
        chk(axis_out[1].state, ST_DECEL);
        chk({fault_relay_output, irq}, 3);
        for (int i = 0; i < 3; i++)
        begin
            wr(A_LSEL, i);
            rdr(A_LDATA, LX[i], RESP_OKAY);
        end
        rdr(A_CNT, 32'h0000_0111, RESP_OKAY);
        wst(0, ST_OFF);
        wst(1, ST_OFF);
        wr(A_FCLR, 32'h0000_0303);
        wr(A_ISTAT, 32'h0000_001f);
        repeat (3) @(posedge clk_sys);
        chk({fault_relay_output, irq}, 0);
    endtask
    task s_grp;
        wr(A_LSEL, '0);
        for (int g = 0; g < 12; g++)
        begin
            ev(1'b1, 1'b1, aso_grp_t'(g), RX_IMMED);
            rdr(A_LDATA, {8'h81, 8'h02, GC[g], 8'h21}, RESP_OKAY);
            wr(A_FCLR, 32'h0000_0200);
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rdr(A_ZT0, {16'h0, RST_ZEROT}, RESP_OKAY);
        rdr(8'h40, '0, RESP_SLVERR);
        s_dis(DM_IMMED);
        s_dis(DM_CTRL);
        s_sto();
        s_stop();
        s_flt();
        s_grp();
        conclude();
    end
endmodule
